// ===== rtl/msc_params.svh
// Constants of the operating-mode and strap configuration block
`ifndef MSC_PARAMS_SVH
`define MSC_PARAMS_SVH

// Clock rate in MHz (100 ns period)
`define MSC_CLK_MHZ 10

// Host reset hold time after power-up or restart, in microseconds
`define MSC_RESET_DELAY_US 10000
// Test pin filter time, in microseconds
`define MSC_TEST_FILT_US 40
// Checksum strap continuous filter time, in microseconds
`define MSC_CRC_FILT_US 20

// Cycle counts derived from the times above
`define MSC_RESET_DELAY_CYC (`MSC_RESET_DELAY_US * `MSC_CLK_MHZ)
`define MSC_TEST_FILT_CYC (`MSC_TEST_FILT_US * `MSC_CLK_MHZ)
`define MSC_CRC_FILT_CYC (`MSC_CRC_FILT_US * `MSC_CLK_MHZ)

// Counter widths
`define MSC_RD_CNT_W 17
`define MSC_FILT_CNT_W 12

// Static recovery frames for the SPI checksum setting
`define MSC_CRC_ON_FRAME 32'h67aaaa0e
`define MSC_CRC_OFF_FRAME 32'he7aaaac3

`endif

// ===== rtl/msc_pkg.sv
// Types of the operating-mode and strap configuration block
package msc_pkg;

    typedef enum logic [2:0] {
        mode_init,
        mode_normal,
        mode_stop,
        mode_sleep,
        mode_restart,
        mode_fail_safe
    } msc_mode_e;

    typedef enum logic [1:0] {
        req_normal,
        req_stop,
        req_sleep
    } msc_req_e;

endpackage

// ===== rtl/msc_filter.sv
// Glitch filter: output follows input only after it stays different long enough
`timescale 1ns/1ps
`include "msc_params.svh"

module msc_filter #(
    parameter int unsigned CYCLES = 4
) (
    input wire logic clk,
    input wire logic ce,
    input wire logic rst,
    input wire logic load,
    input wire logic din,
    output logic q
);

    typedef struct packed {
        logic [`MSC_FILT_CNT_W-1:0] cnt;
        logic q;
    } msc_filt_s;

    localparam logic [`MSC_FILT_CNT_W-1:0] LAST = `MSC_FILT_CNT_W'(CYCLES - 1);

    msc_filt_s st;
    msc_filt_s next_st;

    always_comb begin
        next_st = st;
        if (load) begin
            next_st.q = 1'b1;
            next_st.cnt = '0;
        end else if (din == st.q) begin
            next_st.cnt = '0;
        end else if (st.cnt == LAST) begin
            next_st.q = din;
            next_st.cnt = '0;
        end else begin
            next_st.cnt = st.cnt + `MSC_FILT_CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '{cnt: '0, q: 1'b1};
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign q = st.q;

endmodule

// ===== rtl/msc_mode_ctrl.sv
// Operating-mode state machine with development-mode and checksum strap latching
`timescale 1ns/1ps
`include "msc_params.svh"

module msc_mode_ctrl #(
    parameter int unsigned RESET_DELAY_CYCLES = `MSC_RESET_DELAY_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic test_pin_in,
    input wire logic pwm_checksum_strap_pin,
    input wire logic regulator_above_thr,
    input wire logic power_on_flag,
    input wire logic spi_frame_valid,
    input wire logic [31:0] spi_frame,
    input wire logic spi_write,
    input wire logic spi_mode_req,
    input wire msc_pkg::msc_req_e spi_mode_sel,
    input wire logic spi_soft_reset,
    input wire logic spi_exempt,
    input wire logic wake_event,
    input wire logic wd_fail,
    input wire logic wd_reset_reenable,
    input wire logic thermal_shutdown,
    input wire logic cfg_high_side,
    input wire logic cfg_bridge,
    input wire logic cfg_charge_pump,
    input wire logic cfg_can,
    input wire logic cfg_lin,
    input wire logic cfg_cyc_sense,
    input wire logic cfg_cyc_wake,
    output msc_pkg::msc_mode_e mode,
    output logic host_reset_out_n,
    output logic test_pin_pullup_en,
    output logic dev_mode,
    output logic checksum_en,
    output logic spi_fail,
    output logic wd_fail_int,
    output logic supervision_long_window,
    output logic supervision_timer_run,
    output logic supervision_cfg_hold,
    output logic main_regulator_en,
    output logic high_side_switches_en,
    output logic bridge_drivers_en,
    output logic charge_pump_en,
    output logic can_en,
    output logic lin_en,
    output logic cyc_sense_en,
    output logic cyc_wake_en
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        msc_pkg::msc_mode_e mode;
        logic [`MSC_RD_CNT_W-1:0] rd_cnt;
        logic rst_out_n;
        logic por_start;
        logic dev_mode;
        logic checksum_en;
        logic spi_fail;
        logic wd_int;
        logic long_win;
        logic reg_en;
        logic hs_en;
        logic bd_en;
        logic cp_en;
        logic can_en;
        logic lin_en;
        logic cs_en;
        logic cw_en;
        logic test_s1;
        logic test_s2;
        logic strap_s1;
        logic strap_s2;
    } msc_state_s;

    localparam logic [`MSC_RD_CNT_W-1:0] RD_LAST = `MSC_RD_CNT_W'(RESET_DELAY_CYCLES - 1);

    msc_state_s st;
    msc_state_s next_st;
    logic test_filt;
    logic strap_filt;
    logic filt_load;
    logic monitoring;
    logic crc_window;
    logic by_spi;
    logic wd_to_reset;
    logic stop_blocked;

    // ****************************************************************
    // Pin filters
    // ****************************************************************
    msc_filter #(.CYCLES(`MSC_TEST_FILT_CYC)) u_test_filt (
        .clk(clk),
        .ce(ce),
        .rst(rst),
        .load(filt_load),
        .din(st.test_s2),
        .q(test_filt)
    );

    msc_filter #(.CYCLES(`MSC_CRC_FILT_CYC)) u_strap_filt (
        .clk(clk),
        .ce(ce),
        .rst(rst),
        .load(1'b0),
        .din(st.strap_s2),
        .q(strap_filt)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_st = st;
        by_spi = 1'b0;
        next_st.test_s1 = test_pin_in;
        next_st.test_s2 = st.test_s1;
        next_st.strap_s1 = pwm_checksum_strap_pin;
        next_st.strap_s2 = st.strap_s1;
        next_st.spi_fail = 1'b0;
        next_st.wd_int = 1'b0;
        next_st.long_win = 1'b0;

        monitoring = st.mode == msc_pkg::mode_init && st.por_start && regulator_above_thr
                     && power_on_flag && st.rst_out_n;
        crc_window = ((st.mode == msc_pkg::mode_init && st.por_start)
                      || st.mode == msc_pkg::mode_restart)
                     && regulator_above_thr && power_on_flag && !st.rst_out_n;
        wd_to_reset = wd_fail && (!st.dev_mode || wd_reset_reenable);
        stop_blocked = st.mode == msc_pkg::mode_stop && spi_frame_valid && spi_write
                       && !spi_soft_reset && !spi_exempt
                       && !(spi_mode_req && spi_mode_sel == msc_pkg::req_normal);

        if (st.dev_mode && wd_fail && !wd_reset_reenable
            && (st.mode == msc_pkg::mode_init || st.mode == msc_pkg::mode_normal
                || st.mode == msc_pkg::mode_stop)) begin
            next_st.wd_int = 1'b1;
        end
        next_st.spi_fail = stop_blocked;

        if (thermal_shutdown) begin
            next_st.mode = msc_pkg::mode_fail_safe;
            next_st.rst_out_n = 1'b0;
        end else if (spi_frame_valid && spi_soft_reset) begin
            next_st.mode = msc_pkg::mode_init;
            by_spi = 1'b1;
        end else begin
            unique case (st.mode)
                msc_pkg::mode_init, msc_pkg::mode_normal, msc_pkg::mode_stop: begin
                    if (!st.rst_out_n) begin
                        if (st.rd_cnt != RD_LAST) begin
                            next_st.rd_cnt = st.rd_cnt + `MSC_RD_CNT_W'(1);
                        end else if (regulator_above_thr) begin
                            next_st.rst_out_n = 1'b1;
                        end
                    end else if (wd_to_reset || !regulator_above_thr) begin
                        next_st.mode = msc_pkg::mode_restart;
                    end else if (spi_frame_valid && spi_mode_req && !stop_blocked) begin
                        by_spi = 1'b1;
                        unique case (spi_mode_sel)
                            msc_pkg::req_normal: next_st.mode = msc_pkg::mode_normal;
                            msc_pkg::req_stop: next_st.mode = msc_pkg::mode_stop;
                            msc_pkg::req_sleep: next_st.mode = msc_pkg::mode_sleep;
                            default: next_st.mode = st.mode;
                        endcase
                    end
                end
                msc_pkg::mode_sleep, msc_pkg::mode_fail_safe: begin
                    if (wake_event) begin
                        next_st.mode = msc_pkg::mode_restart;
                    end
                end
                msc_pkg::mode_restart: begin
                    if (st.rd_cnt != RD_LAST) begin
                        next_st.rd_cnt = st.rd_cnt + `MSC_RD_CNT_W'(1);
                    end else if (regulator_above_thr) begin
                        next_st.mode = msc_pkg::mode_normal;
                        next_st.rst_out_n = 1'b1;
                    end
                end
            endcase
        end

        // Host reset is held low for the whole restart
        if (next_st.mode == msc_pkg::mode_restart && st.mode != msc_pkg::mode_restart) begin
            next_st.rst_out_n = 1'b0;
            next_st.rd_cnt = '0;
        end
        if (next_st.mode == msc_pkg::mode_fail_safe) begin
            next_st.rd_cnt = '0;
        end
        filt_load = next_st.rst_out_n && !st.rst_out_n;
        next_st.long_win = filt_load;

        // Strap latched at the release of host reset
        if (filt_load && crc_window) begin
            next_st.checksum_en = !strap_filt;
        end
        if (st.mode == msc_pkg::mode_normal && spi_frame_valid) begin
            if (spi_frame == `MSC_CRC_ON_FRAME) begin
                next_st.checksum_en = 1'b1;
            end else if (spi_frame == `MSC_CRC_OFF_FRAME) begin
                next_st.checksum_en = 1'b0;
            end
        end

        // Development mode latch and its withdrawal
        if (monitoring) begin
            if (next_st.mode != st.mode && !by_spi) begin
                next_st.dev_mode = 1'b0;
            end else if (spi_frame_valid && !test_filt) begin
                next_st.dev_mode = 1'b1;
            end
        end
        if (st.mode == msc_pkg::mode_init && next_st.mode != msc_pkg::mode_init) begin
            next_st.por_start = 1'b0;
        end

        // Function enables per mode
        unique case (next_st.mode)
            msc_pkg::mode_init: begin
                next_st.reg_en = 1'b1;
                next_st.hs_en = 1'b0;
                next_st.bd_en = 1'b0;
                next_st.cp_en = 1'b0;
                next_st.cs_en = 1'b0;
                next_st.cw_en = 1'b0;
                next_st.can_en = next_st.dev_mode;
                next_st.lin_en = next_st.dev_mode;
            end
            msc_pkg::mode_normal: begin
                next_st.reg_en = 1'b1;
                next_st.hs_en = cfg_high_side;
                next_st.bd_en = cfg_bridge;
                next_st.cp_en = cfg_charge_pump;
                next_st.cs_en = cfg_cyc_sense;
                next_st.cw_en = cfg_cyc_wake;
                next_st.can_en = cfg_can;
                next_st.lin_en = cfg_lin;
            end
            msc_pkg::mode_stop: begin
                next_st.reg_en = 1'b1;
                next_st.bd_en = 1'b0;
                next_st.cp_en = 1'b0;
            end
            msc_pkg::mode_sleep: begin
                next_st.reg_en = 1'b0;
                next_st.bd_en = 1'b0;
                next_st.cp_en = 1'b0;
            end
            msc_pkg::mode_restart, msc_pkg::mode_fail_safe: begin
                next_st.reg_en = next_st.mode == msc_pkg::mode_restart;
                next_st.hs_en = 1'b0;
                next_st.bd_en = 1'b0;
                next_st.cp_en = 1'b0;
                next_st.cs_en = 1'b0;
                next_st.cw_en = 1'b0;
                next_st.can_en = 1'b0;
                next_st.lin_en = 1'b0;
            end
            default: next_st.reg_en = 1'b1;
        endcase
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
            st.mode <= msc_pkg::mode_init;
            st.por_start <= 1'b1;
            st.reg_en <= 1'b1;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign mode = st.mode;
    assign host_reset_out_n = st.rst_out_n;
    assign test_pin_pullup_en = st.rst_out_n;
    assign dev_mode = st.dev_mode;
    assign checksum_en = st.checksum_en;
    assign spi_fail = st.spi_fail;
    assign wd_fail_int = st.wd_int;
    assign supervision_long_window = st.long_win;
    assign supervision_timer_run = st.mode == msc_pkg::mode_init
        || st.mode == msc_pkg::mode_normal || st.mode == msc_pkg::mode_stop;
    assign supervision_cfg_hold = st.mode != msc_pkg::mode_normal;
    assign main_regulator_en = st.reg_en;
    assign high_side_switches_en = st.hs_en;
    assign bridge_drivers_en = st.bd_en;
    assign charge_pump_en = st.cp_en;
    assign can_en = st.can_en;
    assign lin_en = st.lin_en;
    assign cyc_sense_en = st.cs_en;
    assign cyc_wake_en = st.cw_en;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_soft_reset_init: assert property (
        ce && spi_frame_valid && spi_soft_reset && !thermal_shutdown
        |=> mode == msc_pkg::mode_init)
        else $error("soft reset did not enter init");
    a_thermal_failsafe: assert property (
        ce && thermal_shutdown |=> mode == msc_pkg::mode_fail_safe && !main_regulator_en)
        else $error("thermal shutdown did not enter fail-safe");
    a_stop_regulator: assert property (
        mode == msc_pkg::mode_stop |-> main_regulator_en && !bridge_drivers_en)
        else $error("stop mode supply settings wrong");
    a_sleep_regulator: assert property (
        mode == msc_pkg::mode_sleep |-> !main_regulator_en && !charge_pump_en)
        else $error("sleep mode regulator not off");
    a_restart_reset: assert property (
        mode == msc_pkg::mode_restart |-> !host_reset_out_n)
        else $error("host reset released during restart");
    a_dev_wd_int: assert property (
        ce && dev_mode && !wd_reset_reenable && wd_fail && mode == msc_pkg::mode_normal
        && !thermal_shutdown && !spi_frame_valid && regulator_above_thr
        |=> wd_fail_int && mode == msc_pkg::mode_normal)
        else $error("development watchdog failure mishandled");
    a_wd_reenable: assert property (
        ce && wd_reset_reenable && wd_fail && mode == msc_pkg::mode_normal
        && !thermal_shutdown && !spi_frame_valid
        |=> mode == msc_pkg::mode_restart ##1 !host_reset_out_n)
        else $error("re-enabled watchdog reset not applied");
    a_long_window: assert property (
        $rose(host_reset_out_n) |-> supervision_long_window && test_pin_pullup_en)
        else $error("long window not started at reset release");
    a_init_outputs: assert property (
        mode == msc_pkg::mode_init |-> main_regulator_en && !high_side_switches_en
        && !charge_pump_en && !cyc_wake_en && can_en == dev_mode && lin_en == dev_mode)
        else $error("init mode enables wrong");
    a_crc_recover_on: assert property (
        ce && mode == msc_pkg::mode_normal && spi_frame_valid
        && spi_frame == `MSC_CRC_ON_FRAME |=> checksum_en)
        else $error("checksum recovery enable ignored");
    a_crc_recover_off: assert property (
        ce && mode == msc_pkg::mode_normal && spi_frame_valid
        && spi_frame == `MSC_CRC_OFF_FRAME |=> !checksum_en)
        else $error("checksum recovery disable ignored");
    a_crc_strap_latch: assert property (
        $rose(host_reset_out_n) && $past(ce) && $past(crc_window)
        |-> checksum_en == !$past(strap_filt))
        else $error("checksum strap not latched at reset release");
    a_stop_ignore: assert property (
        ce && mode == msc_pkg::mode_stop && spi_frame_valid && spi_write && spi_mode_req
        && spi_mode_sel == msc_pkg::req_sleep && !spi_soft_reset && !spi_exempt
        && !thermal_shutdown && !wd_fail && regulator_above_thr && host_reset_out_n
        |=> spi_fail && mode == msc_pkg::mode_stop)
        else $error("stop mode write not refused");
    a_dev_entry: assert property (
        ce && monitoring && spi_frame_valid && !test_filt && !wd_fail
        && !thermal_shutdown |=> dev_mode)
        else $error("development mode not latched");

    c_dev_entry: cover property (ce && monitoring && spi_frame_valid && !test_filt);
    c_restart_exit: cover property (mode == msc_pkg::mode_restart
        ##1 mode == msc_pkg::mode_normal);
    c_crc_recover: cover property (ce && mode == msc_pkg::mode_normal && spi_frame_valid
        && spi_frame == `MSC_CRC_ON_FRAME);
    c_sleep_wake: cover property (mode == msc_pkg::mode_sleep
        ##1 mode == msc_pkg::mode_restart);

endmodule

// ===== testbench/msc_host_model.sv
// Host-side model that issues decoded 32-bit SPI frames toward the mode block
`timescale 1ns/1ps
module msc_host_model (
    input wire logic clk,
    output logic spi_frame_valid,
    output logic [31:0] spi_frame,
    output logic spi_write,
    output logic spi_mode_req,
    output msc_pkg::msc_req_e spi_mode_sel,
    output logic spi_soft_reset,
    output logic spi_exempt
);
    initial begin
        spi_frame_valid = 1'b0;
        spi_frame = 32'h0;
        spi_write = 1'b0;
        spi_mode_req = 1'b0;
        spi_mode_sel = msc_pkg::req_normal;
        spi_soft_reset = 1'b0;
        spi_exempt = 1'b0;
    end
    // One frame per valid pulse; released fields other than spi_mode_sel show the inverse of the last value
    task automatic send(input logic [31:0] f, input logic wr, input logic mreq,
                        input msc_pkg::msc_req_e sel);
        @(posedge clk);
        #10;
        spi_frame_valid = 1'b1;
        spi_frame = f;
        spi_write = wr;
        spi_mode_req = mreq;
        spi_mode_sel = sel;
        spi_soft_reset = 1'b0;
        spi_exempt = 1'b0;
        @(posedge clk);
        #10;
        spi_frame_valid = 1'b0;
        spi_frame = ~f;
        spi_write = ~wr;
        spi_mode_req = ~mreq;
        spi_soft_reset = 1'b1;
        spi_exempt = 1'b1;
    endtask
    // Write frame carrying a soft reset or an exempt (refresh, status) command
    task automatic send_flags(input logic [31:0] f, input logic sr, input logic ex);
        @(posedge clk);
        #10;
        spi_frame_valid = 1'b1;
        spi_frame = f;
        spi_write = 1'b1;
        spi_mode_req = 1'b0;
        spi_soft_reset = sr;
        spi_exempt = ex;
        @(posedge clk);
        #10;
        spi_frame_valid = 1'b0;
        spi_frame = ~f;
        spi_write = 1'b0;
        spi_mode_req = 1'b1;
        spi_soft_reset = ~sr;
        spi_exempt = ~ex;
    endtask
endmodule

// ===== testbench/msc_mode_ctrl_tb.sv
// Self-checking bench of the operating-mode and strap block
`timescale 1ns/1ps
`include "msc_params.svh"
module msc_mode_ctrl_tb;
    logic clk, rst, ce, test_pin_in, pwm_checksum_strap_pin, regulator_above_thr, power_on_flag;
    logic spi_frame_valid, spi_write, spi_mode_req, spi_soft_reset, spi_exempt;
    logic [31:0] spi_frame;
    msc_pkg::msc_req_e spi_mode_sel;
    logic wake_event, wd_fail, wd_reset_reenable, thermal_shutdown;
    logic cfg_high_side, cfg_bridge, cfg_charge_pump, cfg_can, cfg_lin, cfg_cyc_sense, cfg_cyc_wake;
    msc_pkg::msc_mode_e mode;
    logic host_reset_out_n, test_pin_pullup_en, dev_mode, checksum_en, spi_fail, wd_fail_int;
    logic supervision_long_window, supervision_timer_run, supervision_cfg_hold, main_regulator_en;
    logic high_side_switches_en, bridge_drivers_en, charge_pump_en, can_en, lin_en;
    logic cyc_sense_en, cyc_wake_en;
    int err_count, checked;

    // Reset delay must outlast the strap filter so the strap settles before it is latched
    msc_mode_ctrl #(.RESET_DELAY_CYCLES(250)) i_dut (.*);
    msc_host_model i_host (.*);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask

    // Bounded wait for host reset release, then the release side effects
    task automatic wait_release(input logic exp_crc);
        for (int i = 0; i < 300 && host_reset_out_n !== 1'b1; i++) tick(1);
        chk(supervision_long_window, 1'b1);
        chk(test_pin_pullup_en, 1'b1);
        chk(checksum_en, exp_crc);
    endtask

    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic test_power_up;
        tick(8);
        chk(mode, msc_pkg::mode_init);
        chk({main_regulator_en, high_side_switches_en, bridge_drivers_en, charge_pump_en,
             cyc_sense_en, cyc_wake_en}, 6'h20);
        rst = 1'b0;
        wait_release(1'b1);
        chk(mode, msc_pkg::mode_init);
        chk(supervision_cfg_hold, 1'b1);
        $display("test_power_up done");
    endtask

    task automatic test_dev_entry;
        tick(420);
        i_host.send(32'h0, 1'b0, 1'b0, msc_pkg::req_normal);
        tick(1);
        chk(dev_mode, 1'b1);
        chk({can_en, lin_en}, 2'h3);
        wd_fail = 1'b1;
        tick(1);
        wd_fail = 1'b0;
        chk(wd_fail_int, 1'b1);
        chk({host_reset_out_n, mode}, {1'b1, msc_pkg::mode_init});
        $display("test_dev_entry done");
    endtask

    task automatic test_stop;
        i_host.send(32'h0, 1'b0, 1'b1, msc_pkg::req_normal);
        chk(mode, msc_pkg::mode_normal);
        cfg_bridge = 1'b1;
        cfg_charge_pump = 1'b1;
        tick(2);
        chk({bridge_drivers_en, charge_pump_en}, 2'h3);
        i_host.send(32'h0, 1'b0, 1'b1, msc_pkg::req_stop);
        chk({mode, main_regulator_en, bridge_drivers_en}, {msc_pkg::mode_stop, 2'h2});
        i_host.send(32'h12345678, 1'b1, 1'b0, msc_pkg::req_normal);
        chk({spi_fail, mode}, {1'b1, msc_pkg::mode_stop});
        i_host.send_flags(32'h0, 1'b0, 1'b1);
        chk({spi_fail, mode}, {1'b0, msc_pkg::mode_stop});
        i_host.send(32'h0, 1'b1, 1'b1, msc_pkg::req_normal);
        chk(mode, msc_pkg::mode_normal);
        chk({supervision_timer_run, supervision_cfg_hold}, 2'h2);
        i_host.send_flags(32'h0, 1'b1, 1'b0);
        chk({mode, host_reset_out_n}, {msc_pkg::mode_init, 1'b1});
        i_host.send(32'h0, 1'b0, 1'b1, msc_pkg::req_normal);
        chk(mode, msc_pkg::mode_normal);
        $display("test_stop done");
    endtask

    task automatic test_recovery;
        ce = 1'b0;
        i_host.send(`MSC_CRC_OFF_FRAME, 1'b1, 1'b0, msc_pkg::req_normal);
        chk(checksum_en, 1'b1);
        ce = 1'b1;
        i_host.send(`MSC_CRC_OFF_FRAME, 1'b1, 1'b0, msc_pkg::req_normal);
        chk(checksum_en, 1'b0);
        i_host.send(`MSC_CRC_ON_FRAME, 1'b1, 1'b0, msc_pkg::req_normal);
        chk(checksum_en, 1'b1);
        $display("test_recovery done");
    endtask

    task automatic test_restarts;
        i_host.send(32'h0, 1'b1, 1'b1, msc_pkg::req_sleep);
        chk({mode, main_regulator_en}, {msc_pkg::mode_sleep, 1'b0});
        wake_event = 1'b1;
        tick(1);
        wake_event = 1'b0;
        chk({mode, host_reset_out_n}, {msc_pkg::mode_restart, 1'b0});
        wait_release(1'b1);
        chk(mode, msc_pkg::mode_normal);
        pwm_checksum_strap_pin = 1'b1;
        wd_reset_reenable = 1'b1;
        wd_fail = 1'b1;
        tick(1);
        wd_fail = 1'b0;
        chk({mode, host_reset_out_n}, {msc_pkg::mode_restart, 1'b0});
        wait_release(1'b0);
        thermal_shutdown = 1'b1;
        tick(1);
        thermal_shutdown = 1'b0;
        chk(mode, msc_pkg::mode_fail_safe);
        $display("test_restarts done");
    endtask

    // Second power-on: open strap, development entry, then autonomous mode change
    task automatic test_por_again;
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        chk(dev_mode, 1'b0);
        wait_release(1'b0);
        tick(420);
        i_host.send(32'h0, 1'b0, 1'b0, msc_pkg::req_normal);
        tick(1);
        chk(dev_mode, 1'b1);
        thermal_shutdown = 1'b1;
        tick(1);
        thermal_shutdown = 1'b0;
        chk({mode, dev_mode}, {msc_pkg::mode_fail_safe, 1'b0});
        $display("test_por_again done");
    endtask

    initial begin
        {rst, ce, regulator_above_thr, power_on_flag} = 4'hf;
        {test_pin_in, pwm_checksum_strap_pin, wake_event, wd_fail} = 4'h0;
        {wd_reset_reenable, thermal_shutdown, cfg_high_side, cfg_bridge} = 4'h0;
        {cfg_charge_pump, cfg_can, cfg_lin, cfg_cyc_sense, cfg_cyc_wake} = 5'h0;
        test_power_up();
        test_dev_entry();
        test_stop();
        test_recovery();
        test_restarts();
        test_por_again();
        tally_and_finish();
    end

    initial begin
        #(5000 * 100);
        err_count++;
        tally_and_finish();
    end
endmodule
